// [rtl/key_scan_pkg.sv]
package key_scan_pkg;

    // ==========================================
    // host transfer encodings
    localparam logic [1:0] OP_READ = 2'h0;
    localparam logic [1:0] OP_WRITE = 2'h1;
    localparam logic [1:0] PORT_LOW_NIBBLE = 2'h0;
    localparam logic [1:0] PORT_HIGH_NIBBLE = 2'h1;

    // ==========================================
    // widths and reset values
    localparam int DRIVE_LINES = 16;
    localparam int SENSE_BITS = 8;
    localparam logic [15:0] DRIVE_RESET = 16'h0000;
    localparam logic [7:0] SENSE_RESET = 8'h00;

    // ==========================================
    // scan sequence, counted in address-latch rising and falling edges after the write
    typedef enum logic [2:0] {
        SCAN_IDLE = 3'b000,
        SCAN_ZERO = 3'b001,
        SCAN_ARM = 3'b010,
        SCAN_DRIVE = 3'b011,
        SCAN_HOLD = 3'b100
    } scan_state_e;

    typedef struct packed {
        logic [1:0] op;
        logic [1:0] port;
    } transfer_s;

    typedef struct packed {
        logic strobe;
        logic latch;
    } strobes_s;

endpackage : key_scan_pkg

// [rtl/key_scan_port.sv]
// Functional notes
// - port strobe fall captures port and operation
// - write data taken on strobe rise
// - sense zeroed until latch rise; drive later
// - written value one-hot selects drive line
// - drive lasts exactly one latch period
// - sense inputs latched before drive ends
// - antiscan low while any line driven
// - sense bit high when pressed key couples
// - eight bits latched, split into nibbles
// - every read returns one nibble only
// - port 5 high nibble, port 4 low
// - latched byte kept across read gaps
// - writes ignored until a read executes
// - interface is nibble bus and two strobes
`timescale 1ns/10ps

module key_scan_port (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic port_strobe,
    input wire logic addr_latch,
    input wire logic [3:0] host_nibble_in,
    output logic [3:0] host_nibble_out,
    output logic host_nibble_oe,
    output logic [15:0] drive_lines,
    output logic antiscan,
    output logic sense_zeroing,
    input wire logic [7:0] sense_in
);

    // ==========================================
    // strobe edge detection
    key_scan_pkg::strobes_s strobes_q;
    key_scan_pkg::transfer_s xfer_q;
    key_scan_pkg::scan_state_e state_q;
    key_scan_pkg::scan_state_e state_d;
    logic [3:0] sel_q;
    logic [7:0] sense_q;
    logic unread_q;
    logic in_write_q;
    logic in_read_q;
    logic [15:0] drive_q;
    logic antiscan_q;
    logic zero_q;
    logic [3:0] nib_q;
    logic oe_q;

    wire strobe_fall = strobes_q.strobe & ~port_strobe;
    wire strobe_rise = ~strobes_q.strobe & port_strobe;
    wire latch_fall = strobes_q.latch & ~addr_latch;
    wire latch_rise = ~strobes_q.latch & addr_latch;

    wire [1:0] op_now = host_nibble_in[3:2];
    wire [1:0] port_now = host_nibble_in[1:0];
    // scans go to port 4 or 5 only
    wire is_write = (op_now == key_scan_pkg::OP_WRITE) && !port_now[1];
    wire is_read = (op_now == key_scan_pkg::OP_READ) && !port_now[1];

    wire write_ok = is_write && !unread_q && (state_q == key_scan_pkg::SCAN_IDLE);
    wire write_data = in_write_q && strobe_rise;
    logic [15:0] decoded;
    for (genvar i = 0; i < 16; i++) begin : g_decode
        assign decoded[i] = (sel_q == 4'(i));
    end

    // nibble select by port
    // the port is taken from the bus on the fall cycle, so the first driven nibble is already right
    wire [1:0] nib_port = strobe_fall ? port_now : xfer_q.port;
    wire [3:0] read_nibble = (nib_port == key_scan_pkg::PORT_HIGH_NIBBLE) ? sense_q[7:4] : sense_q[3:0];

    // ==========================================
    // scan sequence
    always_comb begin
        state_d = state_q;
        case (state_q)
            key_scan_pkg::SCAN_IDLE: begin
                if (write_data) begin
                    state_d = key_scan_pkg::SCAN_ZERO;
                end
            end
            key_scan_pkg::SCAN_ZERO: begin
                if (latch_rise) begin
                    state_d = key_scan_pkg::SCAN_ARM;
                end
            end
            key_scan_pkg::SCAN_ARM: begin
                if (latch_fall) begin
                    state_d = key_scan_pkg::SCAN_DRIVE;
                end
            end
            key_scan_pkg::SCAN_DRIVE: begin
                if (latch_rise) begin
                    state_d = key_scan_pkg::SCAN_HOLD;
                end
            end
            key_scan_pkg::SCAN_HOLD: begin
                if (latch_fall) begin
                    state_d = key_scan_pkg::SCAN_IDLE;
                end
            end
            default: begin
                state_d = key_scan_pkg::SCAN_IDLE;
            end
        endcase
    end

    wire drive_on = (state_d == key_scan_pkg::SCAN_DRIVE) || (state_d == key_scan_pkg::SCAN_HOLD);
    // sample at latch rise inside drive
    wire sample = (state_q == key_scan_pkg::SCAN_DRIVE) && latch_rise;
    wire read_done = in_read_q && strobe_rise;

    // ==========================================
    // strobe history
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            strobes_q <= '{strobe: 1'b1, latch: 1'b0};
        end else begin
            strobes_q <= '{strobe: port_strobe, latch: addr_latch};
        end
    end

    // ==========================================
    // transfer capture
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            xfer_q <= '0;
            in_write_q <= 1'b0;
            in_read_q <= 1'b0;
        end else begin
            if (strobe_fall) begin
                xfer_q <= '{op: op_now, port: port_now};
                in_write_q <= write_ok;
                in_read_q <= is_read;
            end else if (strobe_rise) begin
                in_write_q <= 1'b0;
                in_read_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= key_scan_pkg::SCAN_IDLE;
            sel_q <= 4'h0;
        end else begin
            state_q <= state_d;
            if (write_data) begin
                sel_q <= host_nibble_in;
            end
        end
    end

    // byte latch, high on coupling, held until next scan
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            sense_q <= key_scan_pkg::SENSE_RESET;
            unread_q <= 1'b0;
        end else begin
            if (sample) begin
                sense_q <= sense_in;
            end
            if (write_data) begin
                unread_q <= 1'b1;
            end else if (read_done) begin
                unread_q <= 1'b0;
            end
        end
    end

    // ==========================================
    // next values of the pin registers
    wire [15:0] drive_d = drive_on ? decoded : key_scan_pkg::DRIVE_RESET;
    wire antiscan_d = !drive_on;
    // zeroing from accepted write fall until latch rise
    wire zero_d = (state_d == key_scan_pkg::SCAN_ZERO) || (strobe_fall && write_ok) || in_write_q;
    wire oe_d = (in_read_q && !strobe_rise) || (strobe_fall && is_read);

    // ==========================================
    // drive line pins
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            drive_q <= key_scan_pkg::DRIVE_RESET;
        end else begin
            drive_q <= drive_d;
        end
    end

    // ==========================================
    // antiscan pin
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            antiscan_q <= 1'b1;
        end else begin
            antiscan_q <= antiscan_d;
        end
    end

    // ==========================================
    // zeroing pin
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            zero_q <= 1'b0;
        end else begin
            zero_q <= zero_d;
        end
    end

    // ==========================================
    // read nibble pins
    // one nibble per read
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            nib_q <= 4'h0;
        end else begin
            nib_q <= read_nibble;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            oe_q <= 1'b0;
        end else begin
            oe_q <= oe_d;
        end
    end

    assign host_nibble_out = nib_q;
    assign host_nibble_oe = oe_q;
    assign drive_lines = drive_q;
    assign antiscan = antiscan_q;
    assign sense_zeroing = zero_q;

endmodule : key_scan_port

// [verif/key_scan_port_properties.sv]
`timescale 1ns/10ps
module key_scan_port_checker (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic port_strobe,
    input wire logic addr_latch,
    input wire logic [3:0] host_nibble_in,
    input wire logic host_nibble_oe,
    input wire logic [15:0] drive_lines,
    input wire logic antiscan,
    input wire logic sense_zeroing
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    a_antiscan_inverse: assert property (antiscan == !(|drive_lines)) else $error("antiscan");
    a_drive_onehot: assert property ($onehot0(drive_lines)) else $error("onehot");
    a_drive_on_fall: assert property ($rose(|drive_lines) |-> !$past(addr_latch)) else $error("on");
    a_drive_off_fall: assert property ($fell(|drive_lines) |-> !$past(addr_latch)) else $error("off");
    a_zero_no_drive: assert property (sense_zeroing |-> !(|drive_lines)) else $error("zero");
    a_drive_held: assert property (|drive_lines && $past(drive_lines) != 16'h0 |-> $stable(drive_lines))
        else $error("held");
    a_oe_strobe_low: assert property (host_nibble_oe |-> $past(port_strobe) == 1'b0) else $error("oe");
    a_bad_op_silent: assert property ($fell(port_strobe) && host_nibble_in[3] |=> !host_nibble_oe)
        else $error("op");
    a_unused_port: assert property ($fell(port_strobe) && host_nibble_in[1] |=> !host_nibble_oe)
        else $error("port");
    a_read_answer: assert property ($fell(port_strobe) && host_nibble_in == 4'h1 |-> ##[1:2] host_nibble_oe)
        else $error("read");
    c_scan: cover property ($rose(|drive_lines));
    c_read: cover property ($rose(host_nibble_oe));
    c_zero: cover property ($rose(sense_zeroing));
endmodule : key_scan_port_checker
bind key_scan_port key_scan_port_checker chk_u (.clock, .rst_n, .port_strobe, .addr_latch, .host_nibble_in,
    .host_nibble_oe, .drive_lines, .antiscan, .sense_zeroing);

// [verif/host_model.sv]
`timescale 1ns/10ps
module host_model (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [15:0] drive_lines,
    input wire logic [3:0] row,
    input wire logic [7:0] keys,
    output logic addr_latch,
    output logic [7:0] sense_in
);
    // ==========
    // host cycle of eight clocks
    logic [2:0] tick_q;
    always_ff @(posedge clock or negedge rst_n)
        if (!rst_n) tick_q <= 3'h0;
        else tick_q <= tick_q + 3'h1;
    assign addr_latch = tick_q[2];
    // keys couple only on the driven row
    assign sense_in = (drive_lines == 16'h1 << row) ? keys : {5'h0, tick_q} ^ 8'ha5;
endmodule : host_model

// [verif/tb.sv]
`timescale 1ns/10ps
module tb;
    // ==========
    // bench
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic port_strobe = 1'b1;
    logic [3:0] host_drv = 4'h0;
    logic [3:0] host_nibble_in, host_nibble_out, rd;
    logic host_nibble_oe, antiscan, addr_latch, sense_zeroing, zr;
    logic [15:0] drive_lines;
    logic [7:0] sense_in;
    logic [7:0] keys = 8'h00;
    logic [3:0] row = 4'h0;
    int bad_count = 0;
    int checked = 0;
    // host lets go of the bus while the port answers
    assign host_nibble_in = host_nibble_oe ? host_nibble_out : host_drv;
    key_scan_port dut_u (.clock, .rst_n, .port_strobe, .addr_latch, .host_nibble_in, .host_nibble_out,
        .host_nibble_oe, .drive_lines, .antiscan, .sense_zeroing, .sense_in);
    host_model host_u (.clock, .rst_n, .drive_lines, .row, .keys, .addr_latch, .sense_in);
    initial forever #4 clock = ~clock;
    task complete_run;
        $display("mismatches %0d of %0d checks", bad_count, checked);
        if (bad_count == 0 && checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : complete_run
    task chk(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] %0t got %h want %h", $time, seen, exp);
        end
    endtask : chk
    task xfer(input logic [1:0] op, input logic [1:0] port, input logic [3:0] data);
        @(posedge clock) port_strobe <= 1'b0;
        host_drv <= {op, port};
        repeat (3) @(posedge clock);
        rd = host_nibble_out;
        zr = sense_zeroing;
        chk(16'(host_nibble_oe), 16'(op == 2'h0 && !port[1]));
        host_drv <= data;
        @(posedge clock) port_strobe <= 1'b1;
        repeat (3) @(posedge clock);
        chk(16'(host_nibble_oe), 16'h0);
    endtask : xfer
    task wait_lvl(input logic on);
        for (int i = 0; i < 40 && (|drive_lines) != on; i++) @(posedge clock);
    endtask : wait_lvl
    task rd_byte(input logic [7:0] k);
        xfer(key_scan_pkg::OP_READ, key_scan_pkg::PORT_HIGH_NIBBLE, 4'h0);
        chk(16'(rd), 16'(k[7:4]));
        repeat (5) @(posedge clock);
        xfer(key_scan_pkg::OP_READ, key_scan_pkg::PORT_LOW_NIBBLE, 4'h0);
        chk(16'(rd), 16'(k[3:0]));
    endtask : rd_byte
    task t_scan(input logic [3:0] n, input logic [7:0] k);
        row <= n;
        keys <= k;
        xfer(key_scan_pkg::OP_WRITE, key_scan_pkg::PORT_LOW_NIBBLE, n);
        chk(16'(zr), 16'h1);
        wait_lvl(1'b1);
        chk(drive_lines, 16'h1 << n);
        chk(16'(antiscan), 16'h0);
        wait_lvl(1'b0);
        chk(16'(antiscan), 16'h1);
        rd_byte(k);
    endtask : t_scan
    task t_refuse;
        row <= 4'h3;
        keys <= 8'h96;
        xfer(key_scan_pkg::OP_WRITE, key_scan_pkg::PORT_HIGH_NIBBLE, 4'h3);
        repeat (40) @(posedge clock);
        row <= 4'h5;
        xfer(key_scan_pkg::OP_WRITE, key_scan_pkg::PORT_LOW_NIBBLE, 4'h5);
        chk(16'(zr), 16'h0);
        wait_lvl(1'b1);
        chk(drive_lines, 16'h0);
        rd_byte(8'h96);
        t_scan(4'h5, 8'h3c);
    endtask : t_refuse
    task t_ops;
        for (int op = 2; op < 4; op++) begin
            xfer(2'(op), key_scan_pkg::PORT_LOW_NIBBLE, 4'h7);
            wait_lvl(1'b1);
            chk(drive_lines, 16'h0);
            xfer(key_scan_pkg::OP_READ, 2'(op), 4'h0);
        end
        rd_byte(8'h3c);
    endtask : t_ops
    initial begin
        repeat (12) @(posedge clock);
        rst_n <= 1'b1;
        repeat (2) @(posedge clock);
        for (int n = 0; n < 16; n++) t_scan(4'(n), 8'(n * 37 + 5));
        t_refuse();
        t_ops();
        complete_run();
    end
    initial begin
        repeat (20000) @(posedge clock);
        bad_count++;
        complete_run();
    end
endmodule : tb
